// ### acs_map.vh
// Register offsets, field positions, reset values and timing counts of the scan-select block
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_SAMPLE_SEL     12'h000
`define ACS_OFF_BG_CONFIG      12'h004
`define ACS_OFF_HIT_HIGH       12'h008
`define ACS_OFF_HIT_LOW        12'h00c
`define ACS_OFF_SCAN_HIGH      12'h010
`define ACS_OFF_SCAN_LOW       12'h014
`define ACS_OFF_CTU_EN_HIGH    12'h018
`define ACS_OFF_CTU_EN_LOW     12'h01c
`define ACS_OFF_CONTROL        12'h020
`define ACS_OFF_IRQ_STATUS     12'h024
`define ACS_OFF_IRQ_MASK       12'h028
`define ACS_CTL_SCAN_EN        0
`define ACS_CTL_ALT            1
`define ACS_CTL_CM_LO          2
`define ACS_CTL_BG_REQ         4
`define ACS_CTL_CTU_REQ        5
`define ACS_RST_WORD           16'h0000
`define ACS_SEL_SUPPLY         5'h1e
`define ACS_SEL_GROUND         5'h1d
`define ACS_SEL_BANDGAP        5'h1c
`define ACS_SEL_CTU            5'h19
`define ACS_SEL_TEMP           5'h18
`define ACS_SEL_LAST_AN        5'h17
`define ACS_NEG_GROUND         3'h0
`define ACS_CM_LESS            2'h0
`define ACS_CM_GREATER         2'h1
`define ACS_CM_INSIDE          2'h2
`define ACS_CM_OUTSIDE         2'h3
`define ACS_BG_START_US        1000
`define ACS_CLK_MHZ            50
`define ACS_BG_START_CYCLES    (`ACS_BG_START_US * `ACS_CLK_MHZ)
`define ACS_HIT_HIGH_MASK      16'h03ff
`define ACS_SCAN_HIGH_MASK     16'h77ff
`define ACS_CTU_HIGH_MASK      16'h73ff
`define ACS_CTU_HIGH_REDUCED   16'h7300
`define ACS_BG_MASK            16'h000f
`endif

// ### acs_scan_select.v
// Channel select, scan, compare-hit and band gap control of the converter
`timescale 1ns/1ps
`include "acs_map.vh"

module acs_scan_select #(
    parameter        REDUCED         = 0,
    parameter [31:0] BG_START_CYCLES = `ACS_BG_START_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sample_start,
    input  wire        conv_active,
    input  wire        result_write,
    input  wire [4:0]  result_channel,
    input  wire        compare_match,
    input  wire        usb_ref_request,
    input  wire        cmp_ref_request,
    input  wire        core_ref_request,
    output reg  [4:0]  positive_select,
    output reg  [2:0]  negative_select,
    output reg  [31:0] analog_input_enable,
    output reg         supply_connect,
    output reg         ground_connect,
    output reg         band_gap_connect,
    output reg         channel_has_buffer,
    output reg         charge_unit_enable,
    output reg         charge_unit_connect,
    output reg  [3:0]  band_gap_on,
    output reg  [3:0]  band_gap_ready,
    output wire [1:0]  compare_mode,
    output wire        irq
);

    reg  [15:0] sample_input_select;
    reg  [3:0]  band_gap_reference_config;
    reg  [25:0] compare_hit_flags;
    reg  [31:0] scan_include_mask;
    reg  [15:0] charge_unit_enable_high;
    reg  [15:0] charge_unit_enable_low;
    reg  [5:0]  control;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;
    reg         slot_b_turn;
    reg  [4:0]  scan_channel;
    reg  [31:0] bg_count [0:3];
    reg  [3:0]  bg_req_q;
    reg  [4:0]  next_scan;
    reg  [4:0]  active_sel;
    reg  [2:0]  active_neg;
    reg  [31:0] ctu_all;
    reg         found;
    reg  [25:0] hit_set;
    reg  [15:0] rd_word;
    // Separate loop variables so no two combinational processes drive the same one
    integer     i;
    integer     k;

    wire        wr_en = psel & penable & pwrite;
    wire        rd_en = psel & penable & ~pwrite;
    wire [4:0]  slot_a_positive_select = sample_input_select[4:0];
    wire [2:0]  slot_a_negative_select = sample_input_select[7:5];
    wire [4:0]  slot_b_positive_select = sample_input_select[12:8];
    wire [2:0]  slot_b_negative_select = sample_input_select[15:13];
    wire        slot_a_scan_enable     = control[`ACS_CTL_SCAN_EN];
    wire        alternate_slot_select  = control[`ACS_CTL_ALT];
    wire [3:0]  bg_request;
    wire [2:0]  events;
    wire [15:0] ctu_high_mask = REDUCED ? `ACS_CTU_HIGH_REDUCED : `ACS_CTU_HIGH_MASK;

    assign pready       = 1'b1;
    assign pslverr      = 1'b0;
    assign compare_mode = control[`ACS_CTL_CM_LO+1:`ACS_CTL_CM_LO];
    assign bg_request   = {usb_ref_request, control[`ACS_CTL_BG_REQ], cmp_ref_request,
                           core_ref_request};
    assign irq          = |(irq_status & irq_mask);

    // Next included channel above the current one, else the lowest included one
    always @* begin
        next_scan = scan_channel;
        found     = 1'b0;
        for (k = 0; k < 31; k = k + 1) begin
            if (!found && k > scan_channel && scan_include_mask[k]) begin
                next_scan = k[4:0];
                found     = 1'b1;
            end
        end
        for (k = 0; k < 31; k = k + 1) begin
            if (!found && scan_include_mask[k]) begin
                next_scan = k[4:0];
                found     = 1'b1;
            end
        end
    end

    // Slot A or B selection; scanning replaces only the slot A positive code
    always @* begin
        if (alternate_slot_select && slot_b_turn) begin
            active_sel = slot_b_positive_select;
            active_neg = slot_b_negative_select;
        end else begin
            active_sel = slot_a_scan_enable ? scan_channel : slot_a_positive_select;
            active_neg = slot_a_negative_select;
        end
    end

    // Mux decode; reserved codes 26,27 and unused codes connect nothing
    always @* begin
        analog_input_enable = 32'h0000_0000;
        if (active_sel <= `ACS_SEL_LAST_AN)
            analog_input_enable[active_sel] = 1'b1;
        supply_connect     = (active_sel == `ACS_SEL_SUPPLY);
        ground_connect     = (active_sel == `ACS_SEL_GROUND);
        band_gap_connect   = (active_sel == `ACS_SEL_BANDGAP);
        // Codes 24 and 25 leave every input open for the charge unit
        channel_has_buffer = (active_sel <= `ACS_SEL_CTU);
        negative_select    = active_neg;
        positive_select    = active_sel;
        ctu_all            = {charge_unit_enable_high & ctu_high_mask, charge_unit_enable_low};
        // The request bit powers the unit without attaching it to any channel
        charge_unit_enable  = conv_active & (ctu_all[active_sel] | control[`ACS_CTL_CTU_REQ]);
        charge_unit_connect = conv_active & ctu_all[active_sel];
    end

    // Hit flag set terms per channel
    always @* begin
        hit_set = 26'h0;
        for (i = 0; i < 26; i = i + 1) begin
            if (result_channel == i[4:0]) begin
                if (compare_mode == `ACS_CM_OUTSIDE)
                    hit_set[i] = result_write | compare_match;
                else
                    hit_set[i] = compare_match;
            end
        end
        if (REDUCED)
            hit_set[25:16] = 10'h000;
    end

    // A fresh reference request raises an interrupt event, as do a sample start and a compare hit
    assign events = {|hit_set, |(bg_request & ~bg_req_q), sample_start};

    // Read mux; unmapped addresses read zero
    always @* begin
        case (paddr)
            `ACS_OFF_SAMPLE_SEL:  rd_word = sample_input_select;
            `ACS_OFF_BG_CONFIG:   rd_word = {12'h000, band_gap_reference_config};
            `ACS_OFF_HIT_HIGH:    rd_word = {6'h00, compare_hit_flags[25:16]};
            `ACS_OFF_HIT_LOW:     rd_word = compare_hit_flags[15:0];
            `ACS_OFF_SCAN_HIGH:   rd_word = scan_include_mask[31:16];
            `ACS_OFF_SCAN_LOW:    rd_word = scan_include_mask[15:0];
            `ACS_OFF_CTU_EN_HIGH: rd_word = charge_unit_enable_high;
            `ACS_OFF_CTU_EN_LOW:  rd_word = charge_unit_enable_low;
            `ACS_OFF_CONTROL:     rd_word = {10'h000, control};
            `ACS_OFF_IRQ_STATUS:  rd_word = {13'h0000, irq_status};
            `ACS_OFF_IRQ_MASK:    rd_word = {13'h0000, irq_mask};
            default:              rd_word = `ACS_RST_WORD;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_input_select       <= `ACS_RST_WORD;
            band_gap_reference_config <= 4'h0;
            compare_hit_flags         <= 26'h0;
            scan_include_mask         <= 32'h0000_0000;
            charge_unit_enable_high   <= `ACS_RST_WORD;
            charge_unit_enable_low    <= `ACS_RST_WORD;
            control                   <= 6'h00;
            irq_status                <= 3'h0;
            irq_mask                  <= 3'h0;
            slot_b_turn               <= 1'b0;
            scan_channel              <= 5'h00;
            prdata                    <= 32'h0000_0000;
        end else begin
            // Captured in the setup cycle so read data stands while pready is high
            prdata <= (psel && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
            if (wr_en) begin
                case (paddr)
                    `ACS_OFF_SAMPLE_SEL: begin
                        // Only ground is implemented on the negative side; other codes drop
                        sample_input_select[12:0]  <= {pwdata[12:8], 3'h0, pwdata[4:0]};
                        sample_input_select[15:13] <= `ACS_NEG_GROUND;
                    end
                    `ACS_OFF_BG_CONFIG:   band_gap_reference_config <= pwdata[3:0];
                    `ACS_OFF_SCAN_HIGH:   scan_include_mask[31:16] <= pwdata[15:0]
                                                                     & `ACS_SCAN_HIGH_MASK;
                    `ACS_OFF_SCAN_LOW:    scan_include_mask[15:0]  <= pwdata[15:0];
                    `ACS_OFF_CTU_EN_HIGH: charge_unit_enable_high  <= pwdata[15:0]
                                                                     & ctu_high_mask;
                    `ACS_OFF_CTU_EN_LOW:  charge_unit_enable_low   <= pwdata[15:0];
                    `ACS_OFF_CONTROL:     control  <= pwdata[5:0];
                    `ACS_OFF_IRQ_MASK:    irq_mask <= pwdata[2:0];
                    default: ;
                endcase
            end
            // Hardware set wins over a software write in the same cycle
            if (wr_en && paddr == `ACS_OFF_HIT_LOW)
                compare_hit_flags[15:0] <= pwdata[15:0] | hit_set[15:0];
            else
                compare_hit_flags[15:0] <= compare_hit_flags[15:0] | hit_set[15:0];
            if (wr_en && paddr == `ACS_OFF_HIT_HIGH && !REDUCED)
                compare_hit_flags[25:16] <= pwdata[9:0] | hit_set[25:16];
            else
                compare_hit_flags[25:16] <= compare_hit_flags[25:16] | hit_set[25:16];
            // Clear only what the setup-cycle capture reported; later events survive
            if (rd_en && paddr == `ACS_OFF_IRQ_STATUS)
                irq_status <= (irq_status & ~prdata[2:0]) | events;
            else
                irq_status <= irq_status | events;
            // Sample slot toggles on each sample start in alternate mode; the scan pointer advances only while scanning and slot A is offered
            if (sample_start) begin
                if (alternate_slot_select)
                    slot_b_turn <= ~slot_b_turn;
                else
                    slot_b_turn <= 1'b0;
                if (slot_a_scan_enable && !(alternate_slot_select && slot_b_turn))
                    scan_channel <= next_scan;
            end
        end
    end

    // Band gap per user: manual enable and a request both switch it on at the next clock edge and both wait out start-up for ready
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : bg
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bg_count[g]       <= 32'h0000_0000;
                    bg_req_q[g]       <= 1'b0;
                    band_gap_on[g]    <= 1'b0;
                    band_gap_ready[g] <= 1'b0;
                end else begin
                    bg_req_q[g]    <= bg_request[g];
                    band_gap_on[g] <= band_gap_reference_config[g] | bg_request[g];
                    if (!(band_gap_reference_config[g] | bg_request[g]))
                        bg_count[g] <= 32'h0000_0000;
                    else if (bg_count[g] < BG_START_CYCLES)
                        bg_count[g] <= bg_count[g] + 32'h0000_0001;
                    // Pre-enabled reference has already settled when the user asks
                    band_gap_ready[g] <= (band_gap_reference_config[g] | bg_request[g])
                                         && (bg_count[g] >= BG_START_CYCLES - 32'h1);
                end
            end
        end
    endgenerate

endmodule

// ### acs_scan_select_asserts.sv
// Port assertions for the scan-select block
`timescale 1ns/1ps
`include "acs_map.vh"
module acs_scan_select_asserts #(
    parameter        REDUCED         = 0,
    parameter [31:0] BG_START_CYCLES = `ACS_BG_START_CYCLES
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        conv_active,
    input wire        cmp_ref_request,
    input wire [2:0]  negative_select,
    input wire [31:0] analog_input_enable,
    input wire        supply_connect,
    input wire        ground_connect,
    input wire        band_gap_connect,
    input wire        channel_has_buffer,
    input wire        charge_unit_enable,
    input wire        charge_unit_connect,
    input wire [3:0]  band_gap_on,
    input wire [3:0]  band_gap_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bg_start;
        $rose(band_gap_on[1]) && !band_gap_ready[1];
    endsequence
    sequence s_bg_wait;
        !band_gap_ready[1] [*2];
    endsequence
    property p_neg_ground; negative_select == 3'h0; endproperty
    property p_route; (|analog_input_enable) |-> $onehot(analog_input_enable)
        && channel_has_buffer && analog_input_enable[31:24] == 8'h00; endproperty
    property p_no_buf; (supply_connect || ground_connect || band_gap_connect)
        |-> !channel_has_buffer && analog_input_enable == 32'h0; endproperty
    property p_ctu_conv; charge_unit_enable |-> conv_active; endproperty
    property p_ctu_link; charge_unit_connect |-> charge_unit_enable; endproperty
    property p_bg_on; cmp_ref_request |=> band_gap_on[1]; endproperty
    property p_bg_wait; s_bg_start |-> s_bg_wait; endproperty
    property p_bg_ready; (band_gap_ready & ~band_gap_on) == 4'h0; endproperty
    property p_rd_unmapped; psel && penable && !pwrite && paddr > 12'h028 |-> prdata == 32'h0;
    endproperty
    a_neg_ground: assert property (p_neg_ground) else $error("negative select not ground");
    a_route: assert property (p_route) else $error("input route not one-hot");
    a_no_buf: assert property (p_no_buf) else $error("internal input has buffer");
    a_ctu_conv: assert property (p_ctu_conv) else $error("charge unit outside conversion");
    a_ctu_link: assert property (p_ctu_link) else $error("charge unit linked while off");
    a_bg_on: assert property (p_bg_on) else $error("requested reference not on");
    a_bg_wait: assert property (p_bg_wait) else $error("reference ready too early");
    a_bg_ready: assert property (p_bg_ready) else $error("reference ready while off");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule
bind acs_scan_select acs_scan_select_asserts #(.REDUCED(REDUCED),
    .BG_START_CYCLES(BG_START_CYCLES)) u_acs_scan_select_asserts (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .conv_active(conv_active), .cmp_ref_request(cmp_ref_request),
    .negative_select(negative_select), .analog_input_enable(analog_input_enable),
    .supply_connect(supply_connect), .ground_connect(ground_connect),
    .band_gap_connect(band_gap_connect), .channel_has_buffer(channel_has_buffer),
    .charge_unit_enable(charge_unit_enable), .charge_unit_connect(charge_unit_connect),
    .band_gap_on(band_gap_on), .band_gap_ready(band_gap_ready));

// ### tb_top.sv
// Register-level testbench of the scan-select block
`timescale 1ns/1ps
`include "acs_map.vh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, irq, ss, ca, rw, cm, se;
    logic        ur, cr, kr, sup, gnd, bgc, hb, cue, cuc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, aie, a;
    logic [4:0]  rc, ps;
    logic [2:0]  ns;
    logic [3:0]  bon, brdy;
    logic [1:0]  mode;
    logic [15:0] msk [0:8] = '{16'h1f1f, 16'h000f, 16'h03ff, 16'hffff, 16'h77ff,
                               16'hffff, 16'h73ff, 16'hffff, 16'h0000};
    integer      mismatches = 0, comparisons = 0, cycles = 0, i, c, n;
    acs_scan_select #(.BG_START_CYCLES(32'd8)) u_acs_scan_select (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(se), .sample_start(ss), .conv_active(ca),
        .result_write(rw), .result_channel(rc), .compare_match(cm), .usb_ref_request(ur),
        .cmp_ref_request(cr), .core_ref_request(kr), .positive_select(ps),
        .negative_select(ns), .analog_input_enable(aie), .supply_connect(sup),
        .ground_connect(gnd), .band_gap_connect(bgc), .channel_has_buffer(hb),
        .charge_unit_enable(cue), .charge_unit_connect(cuc), .band_gap_on(bon),
        .band_gap_ready(brdy), .compare_mode(mode), .irq(irq));
    task wrap_up;
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data is taken at the edge where pready is seen high; an idle edge follows
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                       output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        chk(se, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, ad, d, q);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, ad, 32'h0, q);
        chk(q, e);
    endtask
    task automatic pulse(input logic [1:0] k, input logic [4:0] ch);
        rc <= ch;
        {ss, rw, cm} <= {k == 2'd0, k == 2'd1, k == 2'd2};
        @(posedge pclk);
        {ss, rw, cm} <= 3'b000;
        @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, ss, ca, rw, cm, ur, cr, kr} = 11'h0;
        {paddr, pwdata, rc} = 49'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 9; i = i + 1) begin
            c = (i == 8) ? 44 : i * 4;
            rd(c[11:0], 32'h0);
            wr(c[11:0], 32'hffffffff);
            rd(c[11:0], {16'h0, msk[i]});
            wr(c[11:0], 32'h0);
        end
        for (c = 0; c < 31; c = c + 1) begin
            if (c != 26 && c != 27) begin
                wr(`ACS_OFF_SAMPLE_SEL, c);
                chk(aie, (c <= 23) ? (32'h1 << c) : 32'h0);
                chk({sup, gnd, bgc, hb}, {c == 30, c == 29, c == 28, c <= 25});
                chk({ps, ns}, {c[4:0], 3'h0});
            end
        end
        // Slot A (code 3) is offered first, and each sample start switches to the other slot (slot B is code 5)
        wr(`ACS_OFF_SAMPLE_SEL, 32'h0503);
        wr(`ACS_OFF_CONTROL, 32'h2);
        chk(aie, 32'h8);
        pulse(2'd0, 5'd0);
        chk(aie, 32'h20);
        pulse(2'd0, 5'd0);
        chk(aie, 32'h8);
        wr(`ACS_OFF_SCAN_LOW, 32'h44);
        wr(`ACS_OFF_SCAN_HIGH, 32'h2);
        wr(`ACS_OFF_CTU_EN_LOW, 32'h40);
        ca <= 1'b1;
        wr(`ACS_OFF_CONTROL, 32'h21);
        n = 0;
        while (aie !== 32'h4 && n < 8) begin
            pulse(2'd0, 5'd0);
            n = n + 1;
        end
        for (i = 0; i < 4; i = i + 1) begin
            c = (i == 1) ? 6 : (i == 2) ? 17 : 2;
            chk(aie, 32'h1 << c);
            chk({cue, cuc}, (c == 6) ? 2'b11 : 2'b10);
            pulse(2'd0, 5'd0);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ACS_OFF_CONTROL, i << 2);
            wr(`ACS_OFF_HIT_LOW, 32'h0);
            wr(`ACS_OFF_HIT_HIGH, 32'h0);
            chk(mode, i);
            pulse(2'd1, 5'd4);
            pulse(2'd2, 5'd20);
            rd(`ACS_OFF_HIT_LOW, (i == 3) ? 32'h10 : 32'h0);
            rd(`ACS_OFF_HIT_HIGH, 32'h10);
        end
        apb(1'b0, `ACS_OFF_IRQ_STATUS, 32'h0, a);
        wr(`ACS_OFF_IRQ_MASK, 32'h0);
        pulse(2'd0, 5'd0);
        chk(irq, 1'b0);
        wr(`ACS_OFF_IRQ_MASK, 32'h1);
        chk(irq, 1'b1);
        rd(`ACS_OFF_IRQ_STATUS, 32'h1);
        chk(irq, 1'b0);
        wr(`ACS_OFF_CONTROL, 32'h10);
        {ur, cr, kr} <= 3'b111;
        repeat (2) @(posedge pclk);
        chk(bon, 4'hf);
        chk(brdy, 4'h0);
        repeat (10) @(posedge pclk);
        chk(brdy, 4'hf);
        rd(`ACS_OFF_IRQ_STATUS, 32'h2);
        {ur, cr, kr} <= 3'b000;
        wr(`ACS_OFF_BG_CONFIG, 32'h2);
        @(posedge pclk);
        chk(bon, 4'h6);
        wrap_up;
    end
endmodule
